/* hdl/dgp_pkg.sv */
/*
  constants, types and helper functions for the debug-shared gpio ports:
  register indices, reset values, debug levels and pin ownership decode.
  assumes a single 50 mhz system clock and an apb register bus.
*/
package dgp_pkg;

  localparam int PORT_W = 8;
  localparam int APB_DW = 32;
  localparam int IDX_W = 30;

  // printed offsets are not word aligned, so they are indices; byte address is 4x
  localparam logic [31:0] IDX_FIRST_LATCH = 32'hFFFF_F061;
  localparam logic [31:0] IDX_SECOND_LATCH = 32'hFFFF_F062;
  localparam logic [31:0] IDX_FIRST_DIR = 32'hFFFF_F065;
  localparam logic [31:0] IDX_SECOND_DIR = 32'hFFFF_F066;
  localparam logic [31:0] IDX_FIRST_FSEL = 32'hFFFF_F069;
  localparam logic [31:0] IDX_FIRST_PU = 32'hFFFF_F06D;
  localparam logic [31:0] IDX_SECOND_PU = 32'hFFFF_F06E;

  localparam logic [PORT_W-1:0] LATCH_RST = 8'hFF;
  localparam logic [PORT_W-1:0] CTRL_RST = 8'h00;
  localparam int FSEL_BIT = 0;

  localparam logic [1:0] DBG_LVL0 = 2'h0;
  localparam logic [1:0] DBG_LVL1 = 2'h1;
  localparam logic [1:0] DBG_LVL2 = 2'h2;
  localparam logic [1:0] DBG_LVL3 = 2'h3;

  typedef enum logic [1:0] {OWN_PORT, OWN_TDATA, OWN_TCTRL} dgp_owner_e;

  // who drives the first port's pins
  function automatic dgp_owner_e dgp_first_owner(input logic [1:0] lvl, input logic fsel);
    dgp_owner_e o;
    o = OWN_PORT;
    if (lvl == DBG_LVL3) o = OWN_TDATA;
    else if (lvl == DBG_LVL2 && fsel) o = OWN_TDATA;
    return o;
  endfunction

  // who drives the second port's pins
  function automatic dgp_owner_e dgp_second_owner(input logic [1:0] lvl, input logic fsel);
    dgp_owner_e o;
    o = OWN_PORT;
    if (lvl == DBG_LVL1 || lvl == DBG_LVL3) o = OWN_TCTRL;
    else if (lvl == DBG_LVL2 && !fsel) o = OWN_TDATA;
    return o;
  endfunction

endpackage

/* hdl/dgp_pin_mux.sv */
/*
  per-port pin multiplexer: chooses between port latch/direction and the
  trace signals of the debug support unit. purely combinational; the caller
  registers the result before it reaches the pins.
*/
`timescale 1ns/1ns
module dgp_pin_mux
  import dgp_pkg::*;
(
  input wire dgp_owner_e owner,
  input wire logic [PORT_W-1:0] latch,
  input wire logic [PORT_W-1:0] dir,
  input wire logic [PORT_W-1:0] trace_data_out,
  input wire logic [PORT_W-1:0] trace_clock_control_out,
  output logic [PORT_W-1:0] pin_out,
  output logic [PORT_W-1:0] pin_oe
);

  // trace ownership forces every pin to drive; registers are left untouched
  always_comb begin
    unique case (owner)
      OWN_PORT: begin
        pin_out = latch;
        pin_oe = dir; // R1
      end
      OWN_TDATA: begin
        pin_out = trace_data_out; // R12
        pin_oe = '1;
      end
      OWN_TCTRL: begin
        pin_out = trace_clock_control_out; // R12
        pin_oe = '1;
      end
      default: begin
        pin_out = latch;
        pin_oe = dir;
      end
    endcase
  end

endmodule

/* hdl/dgp_top.sv */
/*
  two 8-bit gpio ports shared with the debug support unit trace outputs.
  holds the apb slave, port registers, pin input synchronisers and the
  registered pin drivers. assumes debug level and trace signals come from
  logic on clk, and that pad logic resolves pull-ups and output enables.
*/
`timescale 1ns/1ns

// Functional notes
// R1 - each port has eight pins; direction bit one drives, zero reads
// R2 - first port reset: latch all ones, direction and function select zero
// R3 - second port reset: latch all ones, direction zero, all inputs
// R4 - per-bit pull-up enable per port, resets zero, one enables pull-up
// R5 - second port has only a direction register, no function select
// R6 - first port drives trace data when level demands, ignoring its registers
// R7 - level 0 both ports; 1 second trace control; 3 first data, second control
// R8 - level 2: select zero gives second trace data, one gives first trace data
// R9 - second port function follows debug level and first port function select
// R10 - the debug tool, not application code, writes the function select
// R11 - software should avoid port use while an in-circuit debugger is attached
// R12 - trace overrides latch and direction; register contents stay for later
module dgp_top
  import dgp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] debug_level,
  input wire logic [PORT_W-1:0] trace_data_out,
  input wire logic [PORT_W-1:0] trace_clock_control_out,
  input wire logic [PORT_W-1:0] first_port_pin_in,
  output logic [PORT_W-1:0] first_port_pin_out,
  output logic [PORT_W-1:0] first_port_pin_oe,
  output logic [PORT_W-1:0] first_port_pullup,
  input wire logic [PORT_W-1:0] second_port_pin_in,
  output logic [PORT_W-1:0] second_port_pin_out,
  output logic [PORT_W-1:0] second_port_pin_oe,
  output logic [PORT_W-1:0] second_port_pullup
);

  // word index match; printed indices are wider than the bus, only low bits compare
  function automatic logic idx_hit(input logic [31:0] addr, input logic [31:0] idx);
    return addr[31:2] == idx[IDX_W-1:0];
  endfunction

  logic [PORT_W-1:0] first_port_latch_r;
  logic [PORT_W-1:0] second_port_latch_r;
  logic [PORT_W-1:0] first_port_direction_r;
  logic [PORT_W-1:0] second_port_direction_r;
  logic [PORT_W-1:0] first_port_function_select_r;
  logic [PORT_W-1:0] first_port_pullup_enable_r;
  logic [PORT_W-1:0] second_port_pullup_enable_r;

  logic [PORT_W-1:0] first_meta_r;
  logic [PORT_W-1:0] first_sync_r;
  logic [PORT_W-1:0] second_meta_r;
  logic [PORT_W-1:0] second_sync_r;

  logic [APB_DW-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [PORT_W-1:0] first_out_r;
  logic [PORT_W-1:0] first_oe_r;
  logic [PORT_W-1:0] second_out_r;
  logic [PORT_W-1:0] second_oe_r;

  logic setup_phase;
  logic wr_go;
  logic hit;
  logic [APB_DW-1:0] rd_nxt;
  logic [PORT_W-1:0] wbyte;
  logic [PORT_W-1:0] first_view;
  logic [PORT_W-1:0] second_view;
  dgp_owner_e first_owner;
  dgp_owner_e second_owner;
  logic [PORT_W-1:0] first_out_nxt;
  logic [PORT_W-1:0] first_oe_nxt;
  logic [PORT_W-1:0] second_out_nxt;
  logic [PORT_W-1:0] second_oe_nxt;

  // apb phase decode; a write lands only at the completing access edge
  assign setup_phase = psel & ~penable;
  assign wr_go = psel & penable & pready_r & pwrite & hit & pstrb[0];
  assign wbyte = pwdata[PORT_W-1:0];

  // pin inputs are asynchronous: two flops before any logic looks at them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_meta_r <= '0;
      first_sync_r <= '0;
      second_meta_r <= '0;
      second_sync_r <= '0;
    end else begin
      first_meta_r <= first_port_pin_in;
      first_sync_r <= first_meta_r;
      second_meta_r <= second_port_pin_in;
      second_sync_r <= second_meta_r;
    end
  end

  // read view: output bits show the latch, input bits show the pin
  assign first_view = (first_port_direction_r & first_port_latch_r) |
                      (~first_port_direction_r & first_sync_r); // R1
  assign second_view = (second_port_direction_r & second_port_latch_r) |
                       (~second_port_direction_r & second_sync_r); // R1

  // address decode and read data; unmapped addresses answer with an error
  always_comb begin
    rd_nxt = '0;
    hit = 1'b1;
    if (idx_hit(paddr, IDX_FIRST_LATCH)) begin
      rd_nxt[PORT_W-1:0] = first_view;
    end else if (idx_hit(paddr, IDX_SECOND_LATCH)) begin
      rd_nxt[PORT_W-1:0] = second_view;
    end else if (idx_hit(paddr, IDX_FIRST_DIR)) begin
      rd_nxt[PORT_W-1:0] = first_port_direction_r;
    end else if (idx_hit(paddr, IDX_SECOND_DIR)) begin
      rd_nxt = '0; // write-only, reads as zero
    end else if (idx_hit(paddr, IDX_FIRST_FSEL)) begin
      rd_nxt[PORT_W-1:0] = first_port_function_select_r;
    end else if (idx_hit(paddr, IDX_FIRST_PU)) begin
      rd_nxt[PORT_W-1:0] = first_port_pullup_enable_r;
    end else if (idx_hit(paddr, IDX_SECOND_PU)) begin
      rd_nxt[PORT_W-1:0] = second_port_pullup_enable_r;
    end else begin
      hit = 1'b0;
    end
  end

  // answer one cycle after setup: zero wait states, data captured at setup
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= setup_phase;
      pslverr_r <= setup_phase & ~hit;
      if (setup_phase) begin
        prdata_r <= pwrite ? '0 : rd_nxt;
      end
    end
  end

  // first port registers; trace ownership never alters them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_port_latch_r <= LATCH_RST; // R2
      first_port_direction_r <= CTRL_RST; // R2
      first_port_function_select_r <= CTRL_RST; // R2
      first_port_pullup_enable_r <= CTRL_RST; // R4
    end else if (wr_go) begin
      if (idx_hit(paddr, IDX_FIRST_LATCH)) first_port_latch_r <= wbyte;
      if (idx_hit(paddr, IDX_FIRST_DIR)) first_port_direction_r <= wbyte; // R1
      if (idx_hit(paddr, IDX_FIRST_FSEL)) first_port_function_select_r <= wbyte;
      if (idx_hit(paddr, IDX_FIRST_PU)) first_port_pullup_enable_r <= wbyte; // R4
    end
  end

  // second port registers: direction only, no function select
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      second_port_latch_r <= LATCH_RST; // R3
      second_port_direction_r <= CTRL_RST; // R3
      second_port_pullup_enable_r <= CTRL_RST; // R4
    end else if (wr_go) begin
      if (idx_hit(paddr, IDX_SECOND_LATCH)) second_port_latch_r <= wbyte;
      if (idx_hit(paddr, IDX_SECOND_DIR)) second_port_direction_r <= wbyte; // R5
      if (idx_hit(paddr, IDX_SECOND_PU)) second_port_pullup_enable_r <= wbyte; // R4
    end
  end

  // pin ownership from debug level and the first port's select bit
  assign first_owner = dgp_first_owner(debug_level,
                                       first_port_function_select_r[FSEL_BIT]); // R6
  assign second_owner = dgp_second_owner(debug_level,
                                         first_port_function_select_r[FSEL_BIT]); // R9

  dgp_pin_mux u_first_mux (
    .owner(first_owner),
    .latch(first_port_latch_r),
    .dir(first_port_direction_r),
    .trace_data_out(trace_data_out),
    .trace_clock_control_out(trace_clock_control_out),
    .pin_out(first_out_nxt),
    .pin_oe(first_oe_nxt)
  );

  dgp_pin_mux u_second_mux (
    .owner(second_owner),
    .latch(second_port_latch_r),
    .dir(second_port_direction_r),
    .trace_data_out(trace_data_out),
    .trace_clock_control_out(trace_clock_control_out),
    .pin_out(second_out_nxt),
    .pin_oe(second_oe_nxt)
  );

  // pin drivers are registered so the pads see glitch-free levels,
  // at the cost of one cycle of trace latency
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_out_r <= LATCH_RST;
      first_oe_r <= CTRL_RST;
      second_out_r <= LATCH_RST;
      second_oe_r <= CTRL_RST;
    end else begin
      first_out_r <= first_out_nxt; // R7
      first_oe_r <= first_oe_nxt; // R7
      second_out_r <= second_out_nxt; // R8
      second_oe_r <= second_oe_nxt; // R8
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign first_port_pin_out = first_out_r;
  assign first_port_pin_oe = first_oe_r;
  assign second_port_pin_out = second_out_r;
  assign second_port_pin_oe = second_oe_r;
  assign first_port_pullup = first_port_pullup_enable_r;
  assign second_port_pullup = second_port_pullup_enable_r;

  // checks on the port behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // after reset the first port is an input with latch high
  property p_first_reset;
    $fell(sys_rst) |-> first_port_latch_r == LATCH_RST && first_oe_r == CTRL_RST
      && first_port_function_select_r == CTRL_RST;
  endproperty
  a_first_reset: assert property (p_first_reset) else $error("first port reset wrong"); // R2

  // after reset the second port is an input with latch high
  property p_second_reset;
    $fell(sys_rst) |-> second_port_latch_r == LATCH_RST && second_oe_r == CTRL_RST;
  endproperty
  a_second_reset: assert property (p_second_reset) else $error("second port reset wrong"); // R3

  // first port pull-up pins follow a write of their register at the next edge
  property p_pullup_write;
    wr_go && idx_hit(paddr, IDX_FIRST_PU) |=> first_port_pullup == $past(wbyte);
  endproperty
  a_pullup_write: assert property (p_pullup_write) else $error("pull-up write lost"); // R4

  // plain port mode: direction register reaches output enables one cycle later
  property p_port_dir;
    debug_level == DBG_LVL0 |=> first_port_pin_oe == $past(first_port_direction_r)
      && second_port_pin_oe == $past(second_port_direction_r);
  endproperty
  a_port_dir: assert property (p_port_dir) else $error("direction not applied"); // R1

  // second direction register is write-only: read data returns zero
  property p_second_dir_wo;
    setup_phase && !pwrite && idx_hit(paddr, IDX_SECOND_DIR) |=> prdata == '0 && pready;
  endproperty
  a_second_dir_wo: assert property (p_second_dir_wo) else $error("write-only read nonzero"); // R5

  // level 3 puts trace data on the first port whatever its registers say
  property p_level3_first;
    debug_level == DBG_LVL3 |=> first_port_pin_oe == '1
      && first_port_pin_out == $past(trace_data_out);
  endproperty
  a_level3_first: assert property (p_level3_first) else $error("trace data not driven"); // R6

  // levels 1 and 3 put trace clock/control on the second port
  property p_second_tctrl;
    debug_level == DBG_LVL1 || debug_level == DBG_LVL3 |=> second_port_pin_oe == '1
      && second_port_pin_out == $past(trace_clock_control_out);
  endproperty
  a_second_tctrl: assert property (p_second_tctrl) else $error("trace control missing"); // R7

  // level 2 with select clear: second port carries trace data, first stays a port
  property p_level2_sel0;
    debug_level == DBG_LVL2 && !first_port_function_select_r[FSEL_BIT] |=>
      second_port_pin_out == $past(trace_data_out)
      && first_port_pin_oe == $past(first_port_direction_r);
  endproperty
  a_level2_sel0: assert property (p_level2_sel0) else $error("level 2 select 0 wrong"); // R8

  // level 2 with select set: first carries trace data, second stays a port
  property p_level2_sel1;
    debug_level == DBG_LVL2 && first_port_function_select_r[FSEL_BIT] |=>
      first_port_pin_out == $past(trace_data_out)
      && second_port_pin_oe == $past(second_port_direction_r);
  endproperty
  a_level2_sel1: assert property (p_level2_sel1) else $error("level 2 select 1 wrong"); // R9

  // trace ownership leaves the latch untouched while no write happens
  property p_latch_kept;
    debug_level != DBG_LVL0 && !wr_go |=> $stable(first_port_latch_r)
      && $stable(first_port_direction_r);
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("latch changed by trace"); // R12

  // every setup phase is answered in the next cycle, errors only when unmapped
  property p_apb_answer;
    setup_phase |=> pready && pslverr == !$past(hit);
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer wrong");

  // pull-up enables of both ports leave reset cleared
  property p_pu_reset;
    $fell(sys_rst) |-> first_port_pullup == CTRL_RST && second_port_pullup == CTRL_RST;
  endproperty
  a_pu_reset: assert property (p_pu_reset) else $error("pull-up reset wrong"); // R4

  // second port pull-up pins follow a write of their register at the next edge
  property p_pu2_write;
    wr_go && idx_hit(paddr, IDX_SECOND_PU) |=> second_port_pullup == $past(wbyte);
  endproperty
  a_pu2_write: assert property (p_pu2_write) else $error("second pull-up write lost"); // R4

  // level 1 leaves the first port a plain port
  property p_level1_first;
    debug_level == DBG_LVL1 |=> first_port_pin_oe == $past(first_port_direction_r)
      && first_port_pin_out == $past(first_port_latch_r);
  endproperty
  a_level1_first: assert property (p_level1_first) else $error("level 1 port wrong"); // R7

  // second port registers also survive trace ownership
  property p_second_kept;
    debug_level != DBG_LVL0 && !wr_go |=> $stable(second_port_latch_r)
      && $stable(second_port_direction_r);
  endproperty
  a_second_kept: assert property (p_second_kept) else $error("second port changed"); // R12

  // a write with its low byte lane off leaves every latch as it was
  property p_no_lane;
    psel && penable && pready && pwrite && !pstrb[0] |=> $stable(first_port_latch_r)
      && $stable(second_port_latch_r);
  endproperty
  a_no_lane: assert property (p_no_lane) else $error("write without strobe landed");

  // an unmapped access is refused and changes nothing
  property p_unmapped;
    psel && penable && pready && pslverr |=> $stable(first_port_latch_r)
      && $stable(first_port_direction_r) && $stable(second_port_latch_r);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access wrote");

endmodule

/* verif/dgp_pad_model.sv */
/*
  pad model for one eight-pin port: resolves the wire level from the
  block's drive, an external driver and the pull-up, and feeds it back.
  assumes the block's drive wins over the external driver on each bit.
*/
`timescale 1ns/1ns
module dgp_pad_model
  import dgp_pkg::*;
(
  input wire logic clk,
  input wire logic [PORT_W-1:0] pin_out,
  input wire logic [PORT_W-1:0] pin_oe,
  input wire logic [PORT_W-1:0] pu_en,
  input wire logic [PORT_W-1:0] ext_val,
  input wire logic [PORT_W-1:0] ext_oe,
  output logic [PORT_W-1:0] pin_in
);
  logic [PORT_W-1:0] float_r = 8'h00;

  // an undriven pin with no pull-up toggles every cycle on bits 0, 2, 5 and 7 and stays zero on the others, so no read may rely on it
  always @(posedge clk) begin
    float_r <= ~float_r ^ 8'h5A;
  end

  // wire level per bit
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_oe[i]) pin_in[i] = ext_val[i];
      else if (pu_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_r[i];
    end
  end
endmodule

/* verif/test_debug_shared_gpio_ports.sv */
/*
  testbench for the debug-shared gpio ports: apb register access, pin
  ownership per debug level, pull-ups and pad readback.
  assumes a pad model on each port and static trace sources.
*/
`timescale 1ns/1ns
module test_debug_shared_gpio_ports;
  import dgp_pkg::*;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [1:0] debug_level;
  logic [PORT_W-1:0] tdat, tctl, f_in, f_out, f_oe, f_pu, s_in, s_out, s_oe, s_pu, f_xoe;
  logic [PORT_W-1:0] e1, e2, e3, e4;
  int err_count, samples_checked, cycles;

  dgp_top i_dgp_top (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .debug_level(debug_level),
    .trace_data_out(tdat), .trace_clock_control_out(tctl),
    .first_port_pin_in(f_in), .first_port_pin_out(f_out), .first_port_pin_oe(f_oe),
    .first_port_pullup(f_pu), .second_port_pin_in(s_in), .second_port_pin_out(s_out),
    .second_port_pin_oe(s_oe), .second_port_pullup(s_pu));
  dgp_pad_model i_pad_first (.clk(clk), .pin_out(f_out), .pin_oe(f_oe), .pu_en(f_pu),
    .ext_val(8'h5A), .ext_oe(f_xoe), .pin_in(f_in));
  dgp_pad_model i_pad_second (.clk(clk), .pin_out(s_out), .pin_oe(s_oe), .pu_en(s_pu),
    .ext_val(8'h00), .ext_oe(8'h00), .pin_in(s_in));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      err_count = err_count + 1;
      report_and_stop;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] d,
                     input logic [3:0] strb);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[29:0], 2'b00};
    pwdata <= d;
    pstrb <= strb;
    @(posedge clk);
    penable <= 1'b1;
    // no wait limit here: the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [31:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d}, 4'hF);
  endtask

  task automatic rreg(input logic [31:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 32'h0, 4'hF);
    chk(rd, {24'h0, exp});
  endtask

  // let pin changes pass the input synchronisers
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    debug_level = 2'h0;
    tdat = 8'hC3;
    tctl = 8'h96;
    f_xoe = 8'h00;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    settle;
    chk(f_out, 8'hFF);
    chk(f_oe, 8'h00);
    chk(s_out, 8'hFF);
    chk(s_oe, 8'h00);
    chk({f_pu, s_pu}, 16'h0);
    rreg(IDX_FIRST_DIR, 8'h00);
    rreg(IDX_FIRST_FSEL, 8'h00);
    rreg(IDX_FIRST_PU, 8'h00);
    rreg(IDX_SECOND_PU, 8'h00);
    // pull-up lifts an undriven input, then an outside driver overrides it
    wreg(IDX_FIRST_PU, 8'hFF);
    settle;
    chk(f_pu, 8'hFF);
    rreg(IDX_FIRST_LATCH, 8'hFF);
    f_xoe <= 8'hFF;
    settle;
    rreg(IDX_FIRST_LATCH, 8'h5A);
    // mixed directions: outputs read the latch, inputs read the pin
    wreg(IDX_FIRST_DIR, 8'hF0);
    wreg(IDX_FIRST_LATCH, 8'hA5);
    settle;
    chk(f_oe, 8'hF0);
    chk(f_out, 8'hA5);
    rreg(IDX_FIRST_LATCH, 8'hAA);
    apb(1'b1, IDX_FIRST_LATCH, 32'h0, 4'h0);
    settle;
    chk(f_out, 8'hA5);
    wreg(IDX_SECOND_DIR, 8'h0F);
    wreg(IDX_SECOND_LATCH, 8'h3C);
    wreg(IDX_SECOND_PU, 8'hFF);
    settle;
    chk(s_oe, 8'h0F);
    chk(s_out, 8'h3C);
    rreg(IDX_SECOND_DIR, 8'h00);
    rreg(IDX_SECOND_LATCH, 8'hFC);
    // no select register exists beside the second port
    apb(1'b0, IDX_FIRST_FSEL + 32'h1, 32'h0, 4'hF);
    chk({31'h0, er}, 32'h1);
    // every level with both select settings, written as the debug tool would
    for (int k = 0; k < 8; k++) begin
      wreg(IDX_FIRST_FSEL, {7'h0, k[0]});
      debug_level <= k[2:1];
      settle;
      e1 = (k[2:1] == 2'h3 || k == 5) ? tdat : 8'hA5;
      e2 = (k[2:1] == 2'h3 || k == 5) ? 8'hFF : 8'hF0;
      e3 = (k[2:1] == 2'h1 || k[2:1] == 2'h3) ? tctl : (k == 4) ? tdat : 8'h3C;
      e4 = (e3 == 8'h3C) ? 8'h0F : 8'hFF;
      chk(f_out, e1);
      chk(f_oe, e2);
      chk(s_out, e3);
      chk(s_oe, e4);
    end
    // dropping to level 0 restores the kept port settings
    @(posedge clk);
    debug_level <= 2'h0;
    settle;
    chk(f_out, 8'hA5);
    chk(f_oe, 8'hF0);
    chk(s_out, 8'h3C);
    chk(s_oe, 8'h0F);
    report_and_stop;
  end
endmodule
